// ==== hw/rsc_cfg.svh ====
// Constants for the reset strap configuration register bank
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

`define RSC_INDEX_PORT 16'h0022
`define RSC_DATA_PORT 16'h0023
`define RSC_OFS_CPU_MULT_BOOT 8'h4B
`define RSC_OFS_CLK_PIN_PERIPH 8'h4C
`define RSC_OFS_HOST_SYNTH 8'h5F

`define RSC_BIT_CPU_MULT_HI 7
`define RSC_BIT_CPU_MULT_LO 6
`define RSC_BIT_BOOT_WIDTH 0
`define RSC_BIT_PAR_EN 7
`define RSC_BIT_KBD_EN 6
`define RSC_BIT_DOT_DIR 4
`define RSC_BIT_MEM_OUT 3
`define RSC_BIT_HOST_DIR 2
`define RSC_BIT_SER1_EN 1
`define RSC_BIT_SER2_EN 0
`define RSC_SYNTH_LSB 3
`define RSC_SYNTH_MSB 5

`define RSC_INDEX_RESET 8'h00
`define RSC_STRAP_RESET 1'b0

`endif

// ==== hw/rsc_pkg.sv ====
// Types for the reset strap configuration register bank
package rsc_pkg;

  typedef enum logic [1:0] {
    RSC_MULT_RSVD = 2'h0,
    RSC_MULT_X1 = 2'h1,
    RSC_MULT_X2 = 2'h2
  } rsc_mult_e;

  typedef enum logic [2:0] {
    RSC_HCLK_RSVD = 3'h0,
    RSC_HCLK_25 = 3'h1,
    RSC_HCLK_50 = 3'h2,
    RSC_HCLK_60 = 3'h3,
    RSC_HCLK_66 = 3'h4
  } rsc_hclk_e;

  typedef enum logic [1:0] {
    RSC_DESKEW_RSVD = 2'h0,
    RSC_DESKEW_LOW = 2'h1,
    RSC_DESKEW_HIGH = 2'h2
  } rsc_deskew_e;

  // Capture sequencer, Gray coded
  typedef enum logic [1:0] {
    RSC_ST_RESET = 2'b00,
    RSC_ST_CAPTURE = 2'b01,
    RSC_ST_RUN = 2'b11
  } rsc_state_e;

endpackage

// ==== hw/rsc_decode.sv ====
// Decoder from strap levels to clock and speed selections
`timescale 1ns/100ps
`default_nettype none

module rsc_decode
(
  input wire logic i_mult_hi,
  input wire logic i_mult_lo,
  input wire logic [2:0] i_synth_sel,
  input wire logic i_speed_b,
  input wire logic i_speed_a,
  input wire logic i_deskew_a,
  input wire logic i_deskew_b,
  output rsc_pkg::rsc_mult_e o_mult,
  output rsc_pkg::rsc_hclk_e o_hclk,
  output rsc_pkg::rsc_deskew_e o_deskew
);

  always_comb
  begin
    case ({i_mult_lo, i_mult_hi})
      2'b10: o_mult = rsc_pkg::RSC_MULT_X1;
      2'b11: o_mult = rsc_pkg::RSC_MULT_X2;
      default: o_mult = rsc_pkg::RSC_MULT_RSVD;
    endcase
  end

  always_comb
  begin
    o_hclk = rsc_pkg::RSC_HCLK_RSVD;
    if (!i_speed_b && !i_speed_a)
    begin
      case (i_synth_sel)
        3'h0: o_hclk = rsc_pkg::RSC_HCLK_25;
        3'h1: o_hclk = rsc_pkg::RSC_HCLK_50;
        3'h2: o_hclk = rsc_pkg::RSC_HCLK_60;
        3'h3: o_hclk = rsc_pkg::RSC_HCLK_66;
        default: o_hclk = rsc_pkg::RSC_HCLK_RSVD;
      endcase
    end
  end

  always_comb
  begin
    case ({i_deskew_a, i_deskew_b})
      2'b10: o_deskew = rsc_pkg::RSC_DESKEW_LOW;
      2'b01: o_deskew = rsc_pkg::RSC_DESKEW_HIGH;
      default: o_deskew = rsc_pkg::RSC_DESKEW_RSVD;
    endcase
  end

endmodule
`default_nettype wire

// ==== hw/rsc_strap_regs.sv ====
// Strap capture registers behind an index/data I/O port pair
`include "rsc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module rsc_strap_regs
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  // I/O port access
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  output logic o_io_hit,
  // Strap pins
  input wire logic i_cpu_mult_strap_hi,
  input wire logic i_cpu_mult_strap_lo,
  input wire logic i_boot_width_strap,
  input wire logic [2:0] i_host_synth_select_straps,
  input wire logic i_host_speed_strap_b,
  input wire logic i_host_speed_strap_a,
  input wire logic i_parallel_port_enable_strap,
  input wire logic i_keyboard_enable_strap,
  input wire logic i_dot_clock_dir_strap,
  input wire logic i_mem_clock_out_strap,
  input wire logic i_host_clock_dir_strap,
  input wire logic i_serial_one_enable_strap,
  input wire logic i_serial_two_enable_strap,
  input wire logic i_deskew_strap_a,
  input wire logic i_deskew_strap_b,
  // Decoded controls
  output logic o_straps_valid,
  output rsc_pkg::rsc_mult_e o_cpu_mult,
  output logic o_boot_width_16,
  output logic [2:0] o_host_synth_select,
  output rsc_pkg::rsc_hclk_e o_host_clock_speed,
  output rsc_pkg::rsc_deskew_e o_deskew_range,
  output logic o_parallel_port_enable,
  output logic o_keyboard_enable,
  output logic o_dot_clock_out_en,
  output logic o_memory_clock_out_en,
  output logic o_host_clock_out_en,
  output logic o_serial_port_one_enable,
  output logic o_serial_port_two_enable
);

  // ******************************
  // Capture sequencer
  // ******************************
  rsc_pkg::rsc_state_e state;
  rsc_pkg::rsc_state_e next_state;

  always_comb
  begin
    case (state)
      rsc_pkg::RSC_ST_RESET: next_state = rsc_pkg::RSC_ST_CAPTURE;
      rsc_pkg::RSC_ST_CAPTURE: next_state = rsc_pkg::RSC_ST_RUN;
      rsc_pkg::RSC_ST_RUN: next_state = rsc_pkg::RSC_ST_RUN;
      default: next_state = rsc_pkg::RSC_ST_RESET;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      state <= rsc_pkg::RSC_ST_RESET;
    else
      state <= next_state;
  end

  // Straps are sampled once, on the first edge after release;
  // an async reset may only load constants.
  logic capture;
  assign capture = (state == rsc_pkg::RSC_ST_RESET);

  // ******************************
  // Strap storage
  // ******************************
  logic mult_hi;
  logic mult_lo;
  logic boot_width;
  logic [2:0] synth_sel;
  logic speed_b;
  logic speed_a;
  logic deskew_a;
  logic deskew_b;
  logic [7:0] periph;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mult_hi <= `RSC_STRAP_RESET;
      mult_lo <= `RSC_STRAP_RESET;
      boot_width <= `RSC_STRAP_RESET;
      synth_sel <= 3'h0;
      speed_b <= `RSC_STRAP_RESET;
      speed_a <= `RSC_STRAP_RESET;
      deskew_a <= `RSC_STRAP_RESET;
      deskew_b <= `RSC_STRAP_RESET;
    end
    else if (capture)
    begin
      mult_hi <= i_cpu_mult_strap_hi;
      mult_lo <= i_cpu_mult_strap_lo;
      boot_width <= i_boot_width_strap;
      synth_sel <= i_host_synth_select_straps;
      speed_b <= i_host_speed_strap_b;
      speed_a <= i_host_speed_strap_a;
      deskew_a <= i_deskew_strap_a;
      deskew_b <= i_deskew_strap_b;
    end
  end

  // ******************************
  // Index / data port
  // ******************************
  logic [7:0] index;
  logic idx_sel;
  logic data_sel;
  assign idx_sel = (i_io_addr == `RSC_INDEX_PORT);
  assign data_sel = (i_io_addr == `RSC_DATA_PORT);

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      index <= `RSC_INDEX_RESET;
    else if (i_io_wr && idx_sel)
      index <= i_io_wdata;
  end

  // Peripheral register: only the dot clock bit takes writes
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      periph <= 8'h00;
    else if (capture)
    begin
      periph <= 8'h00;
      periph[`RSC_BIT_PAR_EN] <= i_parallel_port_enable_strap;
      periph[`RSC_BIT_KBD_EN] <= i_keyboard_enable_strap;
      periph[`RSC_BIT_DOT_DIR] <= i_dot_clock_dir_strap;
      periph[`RSC_BIT_MEM_OUT] <= i_mem_clock_out_strap;
      periph[`RSC_BIT_HOST_DIR] <= i_host_clock_dir_strap;
      periph[`RSC_BIT_SER1_EN] <= i_serial_one_enable_strap;
      periph[`RSC_BIT_SER2_EN] <= i_serial_two_enable_strap;
    end
    else if (i_io_wr && data_sel && index == `RSC_OFS_CLK_PIN_PERIPH)
      periph[`RSC_BIT_DOT_DIR] <= i_io_wdata[`RSC_BIT_DOT_DIR];
  end

  function automatic logic [7:0] read_mux(input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      `RSC_OFS_CPU_MULT_BOOT:
      begin
        v[`RSC_BIT_CPU_MULT_HI] = mult_hi;
        v[`RSC_BIT_CPU_MULT_LO] = mult_lo;
        v[`RSC_BIT_BOOT_WIDTH] = boot_width;
      end
      `RSC_OFS_CLK_PIN_PERIPH: v = periph;
      `RSC_OFS_HOST_SYNTH: v[`RSC_SYNTH_MSB:`RSC_SYNTH_LSB] = synth_sel;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Read data is registered; valid the cycle after the read strobe
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_io_rdata <= 8'h00;
    else if (i_io_rd && idx_sel)
      o_io_rdata <= index;
    else if (i_io_rd && data_sel)
      o_io_rdata <= read_mux(index);
  end

  assign o_io_hit = idx_sel || data_sel;

  // ******************************
  // Controls
  // ******************************
  // Board is trusted to keep speed legal for times one; no check
  rsc_decode u_decode
  (
    .i_mult_hi(mult_hi),
    .i_mult_lo(mult_lo),
    .i_synth_sel(synth_sel),
    .i_speed_b(speed_b),
    .i_speed_a(speed_a),
    .i_deskew_a(deskew_a),
    .i_deskew_b(deskew_b),
    .o_mult(o_cpu_mult),
    .o_hclk(o_host_clock_speed),
    .o_deskew(o_deskew_range)
  );

  assign o_straps_valid = (state == rsc_pkg::RSC_ST_RUN);
  assign o_boot_width_16 = boot_width;
  assign o_host_synth_select = synth_sel;
  assign o_parallel_port_enable = periph[`RSC_BIT_PAR_EN];
  assign o_keyboard_enable = periph[`RSC_BIT_KBD_EN];
  assign o_dot_clock_out_en = periph[`RSC_BIT_DOT_DIR];
  assign o_memory_clock_out_en = periph[`RSC_BIT_MEM_OUT];
  assign o_host_clock_out_en = periph[`RSC_BIT_HOST_DIR];
  assign o_serial_port_one_enable = periph[`RSC_BIT_SER1_EN];
  assign o_serial_port_two_enable = periph[`RSC_BIT_SER2_EN];

endmodule
`default_nettype wire

// ==== bench/rsc_board_model.sv ====
// Board pull resistor model for the strap pins
`timescale 1ns/100ps
`default_nettype none
module rsc_board_model
(
  input wire logic [16:0] i_pattern,
  output logic [16:0] o_straps
);
  // A times-one board never fits a synth code above 66 MHz
  always_comb
  begin
    o_straps = i_pattern;
    if (i_pattern[1:0] == 2'h2)
    begin
      o_straps[5] = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== bench/rsc_monitor.sv ====
// Port checks for the strap register bank
`timescale 1ns/100ps
`default_nettype none
module rsc_monitor
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  input wire logic [7:0] o_io_rdata,
  input wire logic o_io_hit,
  input wire logic o_straps_valid,
  input wire logic i_cpu_mult_strap_hi,
  input wire logic i_cpu_mult_strap_lo,
  input wire logic [2:0] i_host_synth_select_straps,
  input wire logic i_deskew_strap_a,
  input wire logic i_deskew_strap_b,
  input wire logic [2:0] o_host_synth_select,
  input wire rsc_pkg::rsc_mult_e o_cpu_mult,
  input wire rsc_pkg::rsc_deskew_e o_deskew_range,
  input wire logic o_dot_clock_out_en
);
  logic [7:0] idx;
  logic dat;
  logic wr4c;
  default clocking mon_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  assign dat = o_straps_valid && i_io_addr == 16'h0023;
  assign wr4c = dat && i_io_wr && idx == 8'h4C;
  // Shadow of the index so data accesses can be attributed
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      idx <= 8'h00;
    end
    else if (o_straps_valid && i_io_wr && i_io_addr == 16'h0022)
    begin
      idx <= i_io_wdata;
    end
  end
  a_hit_decode: assert property (o_io_hit == (i_io_addr[15:1] == 15'h0011))
    else $error("port hit decode wrong");
  a_rdata_hold: assert property (!(i_io_rd && o_io_hit) |=> $stable(o_io_rdata))
    else $error("read data moved without a read");
  a_mult_map: assert property ($rose(o_straps_valid) |->
    o_cpu_mult == {i_cpu_mult_strap_lo & i_cpu_mult_strap_hi, i_cpu_mult_strap_lo & !i_cpu_mult_strap_hi})
    else $error("multiplier decode wrong");
  a_deskew_map: assert property ($rose(o_straps_valid) |->
    o_deskew_range == {i_deskew_strap_b & !i_deskew_strap_a, i_deskew_strap_a & !i_deskew_strap_b})
    else $error("deskew decode wrong");
  a_synth_copy: assert property ($rose(o_straps_valid) |-> o_host_synth_select == i_host_synth_select_straps)
    else $error("synth select not captured");
  a_dot_write: assert property (wr4c |=> o_dot_clock_out_en == $past(i_io_wdata[4]))
    else $error("dot clock bit not written");
  a_dot_hold: assert property (o_straps_valid && !wr4c |=> $stable(o_dot_clock_out_en))
    else $error("dot clock bit moved");
  a_synth_rsvd: assert property (dat && i_io_rd && idx == 8'h5F |=> o_io_rdata[7:6] == 2'h0 && o_io_rdata[2:0] == 3'h0)
    else $error("host clock reserved bits set");
  a_mult_rsvd: assert property (dat && i_io_rd && idx == 8'h4B |=> o_io_rdata[5:1] == 5'h00)
    else $error("register one reserved bits set");
  c_dot_write: cover property (wr4c);
  c_synth_read: cover property (dat && i_io_rd && idx == 8'h5F);
  c_mult_x2: cover property (o_cpu_mult == rsc_pkg::RSC_MULT_X2);
endmodule
bind rsc_strap_regs rsc_monitor u_mon (.*);
`default_nettype wire

// ==== bench/test_reset_strap_config_regs.sv ====
// Self-checking bench for the strap register bank
`timescale 1ns/100ps
`default_nettype none
module test_reset_strap_config_regs;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_io_wr = 1'b0;
  logic i_io_rd = 1'b0;
  logic [15:0] i_io_addr = 16'h0000;
  logic [7:0] i_io_wdata = 8'h00;
  logic [16:0] pat = 17'h00000;
  logic [16:0] s;
  logic [7:0] o_io_rdata;
  logic [2:0] o_host_synth_select;
  logic o_io_hit, o_straps_valid, o_boot_width_16, o_parallel_port_enable, o_keyboard_enable;
  logic o_dot_clock_out_en, o_memory_clock_out_en, o_host_clock_out_en;
  logic o_serial_port_one_enable, o_serial_port_two_enable;
  rsc_pkg::rsc_mult_e o_cpu_mult;
  rsc_pkg::rsc_hclk_e o_host_clock_speed;
  rsc_pkg::rsc_deskew_e o_deskew_range;
  int err_count = 0;
  int samples_checked = 0;
  rsc_board_model board (.i_pattern(pat), .o_straps(s));
  rsc_strap_regs uut (.*, .i_cpu_mult_strap_hi(s[0]), .i_cpu_mult_strap_lo(s[1]),
    .i_boot_width_strap(s[2]), .i_host_synth_select_straps(s[5:3]),
    .i_host_speed_strap_b(s[6]), .i_host_speed_strap_a(s[7]),
    .i_parallel_port_enable_strap(s[8]), .i_keyboard_enable_strap(s[9]),
    .i_dot_clock_dir_strap(s[10]), .i_mem_clock_out_strap(s[11]),
    .i_host_clock_dir_strap(s[12]), .i_serial_one_enable_strap(s[13]),
    .i_serial_two_enable_strap(s[14]), .i_deskew_strap_a(s[15]), .i_deskew_strap_b(s[16]));
  initial
  begin
    forever #50 i_clk = ~i_clk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Entered and left 10 ns after an edge; strobe lasts one edge
  task automatic io(input logic [15:0] a, input logic w, input logic [7:0] d);
    i_io_addr = a;
    i_io_wr = w;
    i_io_rd = !w;
    i_io_wdata = d;
    @(posedge i_clk);
    #10;
    i_io_wr = 1'b0;
    i_io_rd = 1'b0;
    @(posedge i_clk);
    #10;
  endtask
  task automatic rd_reg(input logic [7:0] ix, output logic [7:0] v);
    io(16'h0022, 1'b1, ix);
    io(16'h0023, 1'b0, 8'h00);
    v = o_io_rdata;
  endtask
  task automatic wr_reg(input logic [7:0] ix, input logic [7:0] d);
    io(16'h0022, 1'b1, ix);
    io(16'h0023, 1'b1, d);
  endtask
  task automatic t_straps(input logic [16:0] p);
    logic [7:0] v;
    logic [7:0] g;
    logic [2:0] hc;
    pat = p;
    i_arst_n = 1'b0;
    repeat (3) @(posedge i_clk);
    #10;
    i_arst_n = 1'b1;
    repeat (2) @(posedge i_clk);
    #10;
    chk("valid", 8'h01, {7'h00, o_straps_valid});
    rd_reg(8'h4B, v);
    chk("reg4b", {s[0], s[1], 5'h00, s[2]}, v);
    rd_reg(8'h4C, v);
    chk("reg4c", {s[8], s[9], 1'b0, s[10], s[11], s[12], s[13], s[14]}, v);
    rd_reg(8'h5F, v);
    chk("reg5f", {2'h0, s[5:3], 3'h0}, v);
    chk("mult", {6'h00, s[1] & s[0], s[1] & !s[0]}, 8'(o_cpu_mult));
    hc = (s[7:6] == 2'h0 && !s[5]) ? 3'(s[4:3]) + 3'h1 : 3'h0;
    chk("speed", {5'h00, hc}, 8'(o_host_clock_speed));
    chk("deskew", {6'h00, s[16] & !s[15], s[15] & !s[16]}, 8'(o_deskew_range));
    g = {o_parallel_port_enable, o_keyboard_enable, o_dot_clock_out_en, o_memory_clock_out_en,
      o_host_clock_out_en, o_serial_port_one_enable, o_serial_port_two_enable, o_boot_width_16};
    chk("pins", {s[8], s[9], s[10], s[11], s[12], s[13], s[14], s[2]}, g);
    $display("TB: straps %h done", p);
  endtask
  task automatic t_write();
    logic [7:0] v;
    logic [7:0] r;
    logic [7:0] ix [3] = '{8'h4B, 8'h5F, 8'h30};
    rd_reg(8'h4C, r);
    wr_reg(8'h4C, 8'hFF);
    chk("dot_on", 8'h01, {7'h00, o_dot_clock_out_en});
    rd_reg(8'h4C, v);
    chk("set4c", r | 8'h10, v);
    wr_reg(8'h4C, 8'h00);
    rd_reg(8'h4C, v);
    chk("clr4c", r & 8'hEF, v);
    foreach (ix[i])
    begin
      rd_reg(ix[i], r);
      wr_reg(ix[i], 8'hFF);
      rd_reg(ix[i], v);
      chk("readonly", r, v);
    end
    chk("unmapped", 8'h00, v);
    io(16'h0022, 1'b0, 8'h00);
    chk("index", 8'h30, o_io_rdata);
    $display("TB: writes done");
  endtask
  task automatic summarize();
    $display("TB: checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial
  begin
    @(posedge i_clk);
    #10;
    t_straps(17'h08012);
    t_straps(17'h0D51E);
    t_straps(17'h17FE3);
    t_straps(17'h18055);
    t_straps(17'h0000B);
    t_straps(17'h00000);
    t_write();
    summarize();
  end
  initial
  begin
    #1000000;
    err_count++;
    summarize();
  end
endmodule
`default_nettype wire
